// ==== src/idm_pkg.sv ====
// Constants, operation codes and state names of the internal data memory and stack unit.
// Assumes a single 200 MHz core clock and a CPU sequencer that issues one request at a time.
// Operation
// RL1 - 256 byte area plus 1 KB: 1280 bytes
// RL2 - Four banks of eight working registers
// RL3 - Working registers are plain internal RAM bytes
// RL4 - Bytes 20h-2Fh bit addressable, bits 00h-7Fh
// RL5 - Extended region only via stack or universal port
// RL6 - Push increments pointer, then writes
// RL7 - Pop reads, then decrements pointer
// RL8 - Default frames push low 16 PC bits
// RL9 - Reset clears configuration register to 00h
// RL10 - Frame mode: interrupts push/pop 23-bit PC
// RL11 - Top stacked PC byte has bit 7 forced
// RL12 - Frame mode leaves calls and returns alone
// RL13 - Pointer 8 bits normally, 16 when extended
// RL14 - Extension never changes return address layout
// RL15 - All three mode bits are independent
// RL16 - Unloaded pointer pushes first to address 8
// RL17 - Config bits 2,1,0; reserved bits written zero
// RL18 - Software sets addressing bit above 64 KB
// RL19 - Software sets stack modes once only
// RL20 - Direct below 128 is RAM, above is SFR
// RL21 - Indirect uses register 0/1, reaches 256 bytes
// RL22 - Sixteen SFRs ending 0h/8h bit addressable
// RL23 - Unimplemented SFR bits read back as one
// RL24 - Extended addressing is bit OR strap
// RL25 - Register n of bank b at 8b+n
package idm_pkg;
  localparam int RAM_BYTES = 1280;
  localparam logic [10:0] RAM_TOP = 11'h500;
  localparam logic [10:0] INDIRECT_INTERNAL_AREA_TOP = 11'h100;
  localparam logic [7:0] DIR_LIMIT = 8'h80;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam logic [7:0] SPL_ADDR = 8'h81;
  localparam logic [7:0] SPH_ADDR = 8'h96;
  localparam logic [7:0] CFG_ADDR = 8'h97;
  localparam logic [15:0] SP_RESET = 16'h0007;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam int CFG_EAM = 2;
  localparam int CFG_STACK_EXTENSION_BIT = 1;
  localparam int CFG_INTERRUPT_FRAME_MODE_BIT = 0;
  localparam logic [4:0] CFG_RSVD_RD = 5'h1F;
  localparam int PCX_TOP = 7;
  localparam logic [1:0] FRAME_STD = 2'h2;
  localparam logic [1:0] FRAME_EXT = 2'h3;
  localparam logic [7:0] SFR_NO_DATA = 8'hFF;

  typedef enum logic [3:0] {
    OP_REG_RD, OP_REG_WR, OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR,
    OP_BIT_RD, OP_BIT_WR, OP_EXT_RD, OP_EXT_WR, OP_PUSH, OP_POP,
    OP_CALL, OP_INT, OP_RET, OP_RETURN_FROM_INTERRUPT
  } idm_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP} idm_st_t;
endpackage

// ==== src/idm_ram_if.sv ====
// Port bundle between the stack controller and its byte store.
// Assumes both ends sit on ref_clk; reads are combinational.
`timescale 1ns/1ps
interface idm_ram_if;
  logic we;
  logic [10:0] waddr;
  logic [7:0] wdata;
  logic [10:0] raddr_a;
  logic [10:0] raddr_b;
  logic [7:0] rdata_a;
  logic [7:0] rdata_b;
  modport ctrl (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
  modport store (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface

// ==== src/idm_ram.sv ====
// Flip-flop byte store for the whole internal data region.
// Assumes one write and two combinational reads per ref_clk cycle.
`timescale 1ns/1ps
module idm_ram
  import idm_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Access port
  idm_ram_if.store ram
);
  typedef struct packed {
    logic [RAM_BYTES-1:0][7:0] mem;
  } idm_ram_st_t;

  idm_ram_st_t s_r;
  idm_ram_st_t s_nxt;

  // =====================================================================
  // Storage
  // Addresses at or beyond the top of the region drop writes and read ones.
  always_comb begin
    s_nxt = s_r;
    if (ram.we && ram.waddr < RAM_TOP) begin // [RL1]
      s_nxt.mem[ram.waddr] = ram.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_r <= s_nxt;
  end

  assign ram.rdata_a = (ram.raddr_a < RAM_TOP) ? s_r.mem[ram.raddr_a] : SFR_NO_DATA;
  assign ram.rdata_b = (ram.raddr_b < RAM_TOP) ? s_r.mem[ram.raddr_b] : SFR_NO_DATA;
endmodule // idm_ram

// ==== src/idm_top.sv ====
// Internal data memory, register banks, bit area and stack sequencing.
// Assumes the CPU sequencer holds a request until req_ready and owns the other SFRs.
`timescale 1ns/1ps
module idm_top
  import idm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // CPU request
  input wire logic req_valid,
  input wire idm_op_t req_op,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [22:0] req_pc,
  input wire logic [1:0] bank_sel,
  // Non-volatile strap
  input wire logic nv_ext_addr,
  // CPU answer
  output logic req_ready,
  output logic done,
  output logic [7:0] rd_data,
  output logic [22:0] ret_pc,
  // Mode state
  output logic [15:0] stack_ptr,
  output logic ext_addr_active,
  output logic stack_ext,
  output logic frame_mode,
  // Forwarded SFR access
  output logic sfr_req,
  output logic sfr_we,
  output logic sfr_bit_op,
  output logic [7:0] sfr_addr,
  output logic [2:0] sfr_bit,
  output logic [7:0] sfr_wdata
);
  typedef struct packed {
    idm_st_t st;
    logic [1:0] step;
    logic [1:0] nbytes;
    logic [15:0] sp;
    logic [2:0] cfg;
    logic [22:0] pc;
    logic [22:0] ret_pc;
    logic [7:0] rd_data;
    logic done;
    logic ready;
    logic nv_s1;
    logic nv_s2;
    logic ext_act;
    logic sfr_req;
    logic sfr_we;
    logic sfr_bit_op;
    logic [7:0] sfr_addr;
    logic [2:0] sfr_bit;
    logic [7:0] sfr_wdata;
  } idm_top_st_t;

  idm_top_st_t s;
  idm_top_st_t n;
  idm_ram_if ram ();

  idm_ram u_ram (
    .ref_clk(ref_clk),
    .ram(ram)
  );

  // =====================================================================
  // Address helpers
  // A 16-bit pointer past the region maps to an index the store ignores.
  function automatic logic [10:0] sp_index(input logic [15:0] p, input logic e);
    if (!e) begin
      sp_index = {3'h0, p[7:0]};
    end else if (p[15:11] != 5'h00) begin
      sp_index = 11'h7FF;
    end else begin
      sp_index = p[10:0];
    end
  endfunction

  logic stack_extension_bit;
  logic interrupt_frame_mode_bit;
  logic go;
  logic own_sfr;
  logic [15:0] sp_inc;
  logic [15:0] sp_dec;
  logic [10:0] reg_idx;
  logic [10:0] ptr_idx;
  logic [10:0] bit_idx;
  logic [7:0] bmod;

  assign stack_extension_bit = s.cfg[CFG_STACK_EXTENSION_BIT]; // [RL15]
  assign interrupt_frame_mode_bit = s.cfg[CFG_INTERRUPT_FRAME_MODE_BIT];
  assign go = req_valid && s.ready;
  assign own_sfr = (req_addr[7:0] == CFG_ADDR) || (req_addr[7:0] == SPL_ADDR) ||
                   (req_addr[7:0] == SPH_ADDR);
  // Classic mode keeps the pointer 8 bits wide and wrapping inside 256 bytes.
  assign sp_inc = stack_extension_bit ? s.sp + 16'h0001 : {8'h00, s.sp[7:0] + 8'h01}; // [RL13]
  assign sp_dec = stack_extension_bit ? s.sp - 16'h0001 : {8'h00, s.sp[7:0] - 8'h01}; // [RL13]
  assign reg_idx = {6'h00, bank_sel, req_addr[2:0]}; // [RL2] [RL3] [RL25]
  assign ptr_idx = {6'h00, bank_sel, 2'b00, req_addr[0]}; // [RL21]
  assign bit_idx = {3'h0, BIT_BASE[7:4], req_addr[6:3]}; // [RL4]

  // =====================================================================
  // Next state
  always_comb begin
    n = s;
    bmod = ram.rdata_a;
    ram.we = 1'b0;
    ram.waddr = 11'h000;
    ram.wdata = 8'h00;
    ram.raddr_a = 11'h000;
    ram.raddr_b = 11'h000;
    n.done = 1'b0;
    n.sfr_req = 1'b0;
    n.nv_s1 = nv_ext_addr;
    n.nv_s2 = s.nv_s1;
    n.ext_act = s.cfg[CFG_EAM] | s.nv_s2; // [RL24]
    unique case (s.st)
      ST_IDLE: begin
        if (go) begin
          n.done = 1'b1;
          unique case (req_op)
            OP_REG_RD: begin
              ram.raddr_a = reg_idx; // [RL3]
              n.rd_data = ram.rdata_a;
            end
            OP_REG_WR: begin
              ram.we = 1'b1;
              ram.waddr = reg_idx;
              ram.wdata = req_wdata;
            end
            OP_DIR_RD: begin
              n.rd_data = SFR_NO_DATA;
              if (req_addr[7:0] < DIR_LIMIT) begin // [RL20]
                ram.raddr_a = {3'h0, req_addr[7:0]};
                n.rd_data = ram.rdata_a;
              end else if (req_addr[7:0] == CFG_ADDR) begin
                n.rd_data = {CFG_RSVD_RD, s.cfg}; // [RL23] [RL17]
              end else if (req_addr[7:0] == SPL_ADDR) begin
                n.rd_data = s.sp[7:0];
              end else if (req_addr[7:0] == SPH_ADDR) begin
                n.rd_data = stack_extension_bit ? s.sp[15:8] : 8'h00;
              end else begin
                n.sfr_req = 1'b1; // [RL20]
                n.sfr_we = 1'b0;
                n.sfr_bit_op = 1'b0;
                n.sfr_addr = req_addr[7:0];
              end
            end
            OP_DIR_WR: begin
              if (req_addr[7:0] < DIR_LIMIT) begin // [RL20]
                ram.we = 1'b1;
                ram.waddr = {3'h0, req_addr[7:0]};
                ram.wdata = req_wdata;
              end else if (req_addr[7:0] == CFG_ADDR) begin
                n.cfg = req_wdata[2:0]; // [RL17] [RL15]
              end else if (req_addr[7:0] == SPL_ADDR) begin
                n.sp = stack_extension_bit ? {s.sp[15:8], req_wdata} : {8'h00, req_wdata};
              end else if (req_addr[7:0] == SPH_ADDR) begin
                n.sp = stack_extension_bit ? {req_wdata, s.sp[7:0]} : s.sp;
              end else begin
                n.sfr_req = 1'b1;
                n.sfr_we = 1'b1;
                n.sfr_bit_op = 1'b0;
                n.sfr_addr = req_addr[7:0];
                n.sfr_wdata = req_wdata;
              end
            end
            OP_IND_RD: begin
              ram.raddr_b = ptr_idx; // [RL21]
              ram.raddr_a = {3'h0, ram.rdata_b};
              n.rd_data = ram.rdata_a;
            end
            OP_IND_WR: begin
              ram.raddr_b = ptr_idx; // [RL21]
              ram.we = 1'b1;
              ram.waddr = {3'h0, ram.rdata_b};
              ram.wdata = req_wdata;
            end
            OP_BIT_RD, OP_BIT_WR: begin
              if (!req_addr[7]) begin
                ram.raddr_a = bit_idx; // [RL4]
                bmod[req_addr[2:0]] = req_wdata[0];
                n.rd_data = {7'h00, ram.rdata_a[req_addr[2:0]]};
                ram.we = (req_op == OP_BIT_WR);
                ram.waddr = bit_idx;
                ram.wdata = bmod;
              end else begin
                // Bit numbers 80h and up land only on SFR addresses ending 0h or 8h.
                n.rd_data = SFR_NO_DATA;
                n.sfr_req = 1'b1; // [RL22]
                n.sfr_we = (req_op == OP_BIT_WR);
                n.sfr_bit_op = 1'b1;
                n.sfr_addr = {req_addr[7:3], 3'h0};
                n.sfr_bit = req_addr[2:0];
                n.sfr_wdata = {7'h00, req_wdata[0]};
              end
            end
            OP_EXT_RD: begin
              ram.raddr_a = req_addr[10:0]; // [RL5]
              n.rd_data = ram.rdata_a;
            end
            OP_EXT_WR: begin
              ram.we = 1'b1;
              ram.waddr = req_addr[10:0]; // [RL5]
              ram.wdata = req_wdata;
            end
            OP_PUSH: begin
              n.sp = sp_inc; // [RL6]
              ram.we = 1'b1;
              ram.waddr = sp_index(sp_inc, stack_extension_bit); // [RL5] [RL16]
              ram.wdata = req_wdata;
            end
            OP_POP: begin
              ram.raddr_a = sp_index(s.sp, stack_extension_bit); // [RL7]
              n.rd_data = ram.rdata_a;
              n.sp = sp_dec;
            end
            OP_CALL, OP_INT: begin
              // Low byte goes first; the rest follows from the latched PC.
              n.done = 1'b0;
              n.ready = 1'b0;
              n.st = ST_PUSH;
              n.pc = req_pc;
              n.step = 2'h1;
              n.nbytes = (req_op == OP_INT && interrupt_frame_mode_bit) ? FRAME_EXT : FRAME_STD; // [RL8] [RL10] [RL12]
              n.sp = sp_inc; // [RL6]
              ram.we = 1'b1;
              ram.waddr = sp_index(sp_inc, stack_extension_bit); // [RL14]
              ram.wdata = req_pc[7:0];
            end
            OP_RET, OP_RETURN_FROM_INTERRUPT: begin
              n.done = 1'b0;
              n.ready = 1'b0;
              n.st = ST_POP;
              n.step = 2'h1;
              n.nbytes = (req_op == OP_RETURN_FROM_INTERRUPT && interrupt_frame_mode_bit) ? FRAME_EXT : FRAME_STD; // [RL10] [RL12]
              ram.raddr_a = sp_index(s.sp, stack_extension_bit); // [RL7]
              n.ret_pc = {15'h0000, ram.rdata_a};
              n.sp = sp_dec;
            end
          endcase
        end
      end
      ST_PUSH: begin
        n.sp = sp_inc; // [RL6]
        ram.we = 1'b1;
        ram.waddr = sp_index(sp_inc, stack_extension_bit); // [RL14]
        ram.wdata = (s.step == 2'h1) ? s.pc[15:8] : {1'b1, s.pc[22:16]}; // [RL11]
        n.step = s.step + 2'h1;
        if ((s.step + 2'h1) == s.nbytes) begin
          n.st = ST_IDLE;
          n.ready = 1'b1;
          n.done = 1'b1;
        end
      end
      ST_POP: begin
        // Shifting drops the forced top bit of a three-byte frame.
        ram.raddr_a = sp_index(s.sp, stack_extension_bit); // [RL7]
        n.ret_pc = {s.ret_pc[14:0], ram.rdata_a}; // [RL10]
        n.sp = sp_dec;
        n.step = s.step + 2'h1;
        if ((s.step + 2'h1) == s.nbytes) begin
          n.st = ST_IDLE;
          n.ready = 1'b1;
          n.done = 1'b1;
        end
      end
    endcase
    if (!rst_n) begin
      n = '0;
      n.st = ST_IDLE;
      n.cfg = CFG_RESET; // [RL9]
      n.sp = SP_RESET; // [RL16]
      n.ready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= n;
  end

  assign req_ready = s.ready;
  assign done = s.done;
  assign rd_data = s.rd_data;
  assign ret_pc = s.ret_pc;
  assign stack_ptr = s.sp;
  assign ext_addr_active = s.ext_act;
  assign stack_ext = s.cfg[CFG_STACK_EXTENSION_BIT];
  assign frame_mode = s.cfg[CFG_INTERRUPT_FRAME_MODE_BIT];
  assign sfr_req = s.sfr_req;
  assign sfr_we = s.sfr_we;
  assign sfr_bit_op = s.sfr_bit_op;
  assign sfr_addr = s.sfr_addr;
  assign sfr_bit = s.sfr_bit;
  assign sfr_wdata = s.sfr_wdata;

  // =====================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  reset_vals_a: assert property ($rose(rst_n) |-> (s.cfg == CFG_RESET && s.sp == SP_RESET)) // [RL9]
    else $error("Mode or pointer not at reset value.");
  push_order_a: assert property ((go && req_op == OP_PUSH) |-> // [RL6]
      (ram.we && ram.waddr == sp_index(sp_inc, stack_extension_bit)) ##1 (s.sp == $past(sp_inc)))
    else $error("Push did not pre-increment the pointer.");
  pop_order_a: assert property ((go && req_op == OP_POP) |-> // [RL7]
      (ram.raddr_a == sp_index(s.sp, stack_extension_bit)) ##1
      (s.sp == $past(sp_dec) && s.rd_data == $past(ram.rdata_a)))
    else $error("Pop did not read before decrementing.");
  call_frame_a: assert property ((go && req_op == OP_CALL && !stack_extension_bit) |-> // [RL8] [RL12]
      ##2 (s.done && s.sp[7:0] == $past(s.sp[7:0], 2) + 8'h02))
    else $error("Call frame is not two bytes.");
  int_ext_a: assert property ((go && req_op == OP_INT && interrupt_frame_mode_bit) |-> // [RL10]
      ##1 !s.done ##1 !s.done ##1 s.done)
    else $error("Extended interrupt frame is not three bytes.");
  pcx_force_a: assert property ((s.st == ST_PUSH && s.step == 2'h2) |-> // [RL11]
      (ram.we && ram.wdata[PCX_TOP]))
    else $error("Top frame byte lacks its forced bit.");
  sp_confine_a: assert property ((go && req_op == OP_PUSH && !stack_extension_bit) |-> ram.waddr < INDIRECT_INTERNAL_AREA_TOP) // [RL13]
    else $error("Classic pointer left the 256 byte area.");
  dir_sfr_a: assert property ((go && req_op == OP_DIR_RD && !own_sfr && // [RL20]
      req_addr[7:0] >= DIR_LIMIT) |-> (!ram.we ##1 s.sfr_req))
    else $error("High direct address did not go to the SFR port.");
  cfg_rsvd_a: assert property ((go && req_op == OP_DIR_RD && // [RL23]
      req_addr[7:0] == CFG_ADDR) |=>
      (s.rd_data[7:3] == CFG_RSVD_RD && s.rd_data[2:0] == $past(s.cfg)))
    else $error("Configuration read back wrong.");
  ext_act_a: assert property ((s.cfg[CFG_EAM] && $stable(s.cfg)) |=> s.ext_act) // [RL24]
    else $error("Addressing bit did not enable extended addressing.");
endmodule // idm_top

// ==== sim/idm_cpu_model.sv ====
// CPU sequencer model that hands one request at a time to the memory unit.
// Assumes the bench pulses go for one cycle and then waits for done.
`timescale 1ns/1ps
module idm_cpu_model
  import idm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bench command
  input wire logic go,
  input wire idm_op_t op,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [22:0] pc,
  // Request to the unit
  input wire logic req_ready,
  output logic req_valid,
  output idm_op_t req_op,
  output logic [15:0] req_addr,
  output logic [7:0] req_wdata,
  output logic [22:0] req_pc
);
  // ========
  // Request holding
  // After the hand-off address, data and PC are inverted (the op is kept), so a late sample sees junk.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_valid <= 1'b0;
      req_op <= OP_REG_RD;
      req_addr <= 16'h0;
      req_wdata <= 8'h0;
      req_pc <= 23'h0;
    end else if (go) begin
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= addr;
      req_wdata <= wdata;
      req_pc <= pc;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      req_addr <= ~req_addr;
      req_wdata <= ~req_wdata;
      req_pc <= ~req_pc;
    end
  end
endmodule // idm_cpu_model

// ==== sim/internal_data_memory_stack_unit_bench.sv ====
// Self-checking bench for the internal data memory and stack unit.
// Assumes the unit answers every request with a one-cycle done pulse.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module internal_data_memory_stack_unit_bench
  import idm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic nv_ext_addr = 1'b0;
  logic [1:0] bank_sel = 2'h0;
  idm_op_t op = OP_REG_RD;
  logic [15:0] addr = 16'h0;
  logic [7:0] wdata = 8'h0;
  logic [22:0] pc = 23'h0;
  logic req_valid, req_ready, done, ext_addr_active, stack_ext, frame_mode;
  logic sfr_req, sfr_we, sfr_bit_op;
  idm_op_t req_op;
  logic [15:0] req_addr, stack_ptr;
  logic [7:0] req_wdata, rd_data, sfr_addr, sfr_wdata, v, e;
  logic [22:0] req_pc, ret_pc, p;
  logic [2:0] sfr_bit;
  int failures = 0;
  int n_checks = 0;
  int seed = 15;
  int n, k;

  always #2.5 ref_clk = ~ref_clk;

  idm_cpu_model idm_cpu_model_i (.ref_clk, .rst_n, .go, .op, .addr, .wdata, .pc,
    .req_ready, .req_valid, .req_op, .req_addr, .req_wdata, .req_pc);
  idm_top idm_top_i (.ref_clk, .rst_n, .req_valid, .req_op, .req_addr, .req_wdata,
    .req_pc, .bank_sel, .nv_ext_addr, .req_ready, .done, .rd_data, .ret_pc,
    .stack_ptr, .ext_addr_active, .stack_ext, .frame_mode, .sfr_req, .sfr_we,
    .sfr_bit_op, .sfr_addr, .sfr_bit, .sfr_wdata);

  // ========
  // Closing report
  task automatic end_of_test();
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ========
  // Request helpers
  // Each returns at the falling edge where done is high, so pulses are seen.
  task automatic run(input idm_op_t o, input logic [15:0] a, input logic [7:0] d,
                     input logic [22:0] q);
    int t;
    @(posedge ref_clk);
    go <= 1'b1;
    op <= o;
    addr <= a;
    wdata <= d;
    pc <= q;
    @(posedge ref_clk);
    go <= 1'b0;
    t = 0;
    do begin
      @(negedge ref_clk);
      t++;
    end while (done !== 1'b1 && t < 20);
    if (done !== 1'b1) begin
      failures++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    run(OP_DIR_RD, {8'h00, a}, 8'h00, 23'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    run(OP_DIR_WR, {8'h00, a}, d, 23'h0);
  endtask

  function automatic logic [7:0] rb();
    return 8'($random(seed));
  endfunction

  function automatic logic [7:0] setb(logic [7:0] x, int j, logic b);
    x[j] = b;
    return x;
  endfunction

  // ========
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    `CHK("ready", 1'b1, req_ready)
    `CHK("sp", 16'h0007, stack_ptr)
    `CHK("modes", 3'h0, {ext_addr_active, stack_ext, frame_mode})
    rd(8'h97);
    `CHK("cfg", 8'hF8, rd_data)
    v = rb();
    run(OP_PUSH, 16'h0, v, 23'h0);
    `CHK("sp push", 16'h0008, stack_ptr)
    rd(8'h08);
    `CHK("first push", v, rd_data)
    run(OP_POP, 16'h0, 8'h00, 23'h0);
    `CHK("pop", {v, 16'h0007}, {rd_data, stack_ptr})
    for (int b = 0; b < 4; b++) begin
      @(posedge ref_clk);
      bank_sel <= 2'(b);
      n = $random(seed) & 7;
      v = rb();
      run(OP_REG_WR, 16'(n), v, 23'h0);
      rd(8'(8 * b + n));
      `CHK("bank", v, rd_data)
      e = rb();
      wr(8'(8 * b + n), e);
      run(OP_REG_RD, 16'(n), 8'h00, 23'h0);
      `CHK("reg alias", e, rd_data)
    end
    v = rb();
    run(OP_REG_WR, 16'h1, 8'h90, 23'h0);
    run(OP_IND_WR, 16'h1, v, 23'h0);
    run(OP_REG_WR, 16'h0, 8'h90, 23'h0);
    run(OP_IND_RD, 16'h0, 8'h00, 23'h0);
    `CHK("indirect", v, rd_data)
    rd(8'h90);
    `CHK("dir sfr", {1'b1, 8'h90, 8'hFF}, {sfr_req, sfr_addr, rd_data})
    `CHK("dir sfr kind", 2'h0, {sfr_we, sfr_bit_op})
    e = ~v;
    wr(8'h90, e);
    `CHK("dir sfr wr", {2'h3, 8'h90, e}, {sfr_req, sfr_we, sfr_addr, sfr_wdata})
    run(OP_IND_RD, 16'h0, 8'h00, 23'h0);
    `CHK("ram kept", v, rd_data)
    for (int i = 0; i < 8; i++) begin
      k = (i == 0) ? 0 : (i == 1) ? 127 : ($random(seed) & 127);
      v = rb();
      e = rb();
      wr(8'(32 + k / 8), v);
      run(OP_BIT_WR, 16'(k), {7'h00, e[0]}, 23'h0);
      rd(8'(32 + k / 8));
      `CHK("bit wr", setb(v, k % 8, e[0]), rd_data)
      run(OP_BIT_RD, 16'(k), 8'h00, 23'h0);
      `CHK("bit rd", e[0], rd_data[0])
    end
    run(OP_BIT_WR, 16'h008B, 8'h01, 23'h0);
    `CHK("sfr bit", 13'h1C43, {sfr_req, sfr_bit_op, sfr_addr, sfr_bit})
    `CHK("sfr bit wr", 9'h101, {sfr_we, sfr_wdata})
    for (int m = 0; m < 2; m++) begin
      wr(8'h97, 8'(m));
      // Modes change only while the stack is empty and the pointer is reloaded.
      wr(8'h81, 8'h07);
      p = 23'($random(seed));
      run(OP_CALL, 16'h0, 8'h00, p);
      `CHK("call sp", 16'h0009, stack_ptr)
      rd(8'h08);
      `CHK("call lo", p[7:0], rd_data)
      rd(8'h09);
      `CHK("call hi", p[15:8], rd_data)
      run(OP_RET, 16'h0, 8'h00, 23'h0);
      `CHK("ret", {p[15:0], 16'h0007}, {ret_pc[15:0], stack_ptr})
      run(OP_INT, 16'h0, 8'h00, p);
      `CHK("int sp", 16'(9 + m), stack_ptr)
      rd(8'h0A);
      if (m == 1) `CHK("int top", {1'b1, p[22:16]}, rd_data)
      run(OP_RETURN_FROM_INTERRUPT, 16'h0, 8'h00, 23'h0);
      `CHK("return_from_interrupt lo", p[15:0], ret_pc[15:0])
      if (m == 1) `CHK("return_from_interrupt", p, ret_pc)
    end
    wr(8'h97, 8'h02);
    wr(8'h96, 8'h03);
    wr(8'h81, 8'hFF);
    `CHK("esp", {1'b1, 16'h03FF}, {stack_ext, stack_ptr})
    v = rb();
    run(OP_PUSH, 16'h0, v, 23'h0);
    `CHK("esp push", 16'h0400, stack_ptr)
    run(OP_EXT_RD, 16'h0400, 8'h00, 23'h0);
    `CHK("ext stack", v, rd_data)
    run(OP_POP, 16'h0, 8'h00, 23'h0);
    `CHK("esp pop", {v, 16'h03FF}, {rd_data, stack_ptr})
    e = rb();
    run(OP_EXT_WR, 16'h04FF, e, 23'h0);
    run(OP_EXT_RD, 16'h04FF, 8'h00, 23'h0);
    `CHK("top byte", e, rd_data)
    run(OP_EXT_RD, 16'h0500, 8'h00, 23'h0);
    `CHK("past top", 8'hFF, rd_data)
    wr(8'h97, 8'h00);
    wr(8'h81, 8'hFF);
    run(OP_PUSH, 16'h0, v, 23'h0);
    `CHK("wrap", 16'h0000, stack_ptr)
    wr(8'h97, 8'h07);
    rd(8'h97);
    `CHK("all modes", 11'h7FF, {rd_data, ext_addr_active, stack_ext, frame_mode})
    // A reset in mid-run must undo every mode bit written above.
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    `CHK("re-reset", {3'h0, 16'h0007}, {ext_addr_active, stack_ext, frame_mode, stack_ptr})
    rd(8'h97);
    `CHK("cfg reset", 8'hF8, rd_data)
    @(posedge ref_clk);
    nv_ext_addr <= 1'b1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("strap", 1'b1, ext_addr_active)
    end_of_test();
  end
endmodule // internal_data_memory_stack_unit_bench
